// ### src/tdcb_board.sv
// Purpose: reset, defaults and front panel control of a tdc board
// Assumes: buffer and tdc status arrive on mclk_i; panel pins are asynchronous
// Notes:   settings are writable only once configuring has ended
// Functional notes
// RULE1 - runs from internal or external clock chosen by static switch
// RULE2 - external clock must not exceed 40 MHz
// RULE3 - clear input held high performs hardware clear, at least 25 ns
// RULE4 - bunch reset on rising edge, pulse at least 25 ns
// RULE5 - trigger rising edge latches tdc data, pulse at least 25 ns
// RULE6 - one control output, function chosen by a control register
// RULE7 - activity indicator lights on every read or write access
// RULE8 - full indicator follows output buffer full
// RULE9 - error indicator follows any tdc global error
// RULE10 - data ready when buffer holds datum or event, per mode
// RULE11 - addressing and transfer modes supported on host bus
// RULE12 - output buffer emptied at power-up
// RULE13 - all software registers load default values at power-up
// RULE14 - tdc flags default: no matching, leading edge, 100 ps, all enabled
// RULE15 - window defaults: width 0x14, offset 0xffd8, search 0x8, reject 0x4
// RULE16 - dead time between hits defaults to 5 ns
// RULE17 - tdc readout fifo size defaults to 256
// RULE18 - no limit on hits per event after power-up
// RULE19 - full, error, data ready lit together while configuring
// RULE20 - host reprograms settings after power-up or hardware reset
// RULE21 - external clock is active on its rising edge
// RULE22 - both trigger inputs are ored together
// RULE23 - hardware clear restores the same defaults as power-up
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tdcb_board #(
  parameter int unsigned NCH         = 128,
  parameter int unsigned CONFIG_CYCLES = tdcb_pkg::CONFIG_CYC
) (
  input  wire logic                        mclk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        clk_ext_sel_i,
  input  wire logic                        hw_clear_i,
  input  wire logic                        bunch_reset_i,
  input  wire logic                        latch_trigger_i,
  input  wire logic                        ext_trigger_i,
  input  wire logic                        buffer_full_i,
  input  wire logic                        buffer_data_i,
  input  wire logic                        buffer_event_i,
  input  wire logic                        tdc_error_i,
  input  wire logic [7:0]                  bus_addr_i,
  input  wire logic [31:0]                 bus_wdata_i,
  input  wire logic                        bus_we_i,
  input  wire logic                        bus_re_i,
  input  wire logic [$clog2(NCH)-1:0]      chan_off_sel_i,
  output logic      [31:0]                 bus_rdata_o,
  output logic                             clk_sel_o,
  output logic                             buffer_clear_o,
  output logic                             bunch_reset_o,
  output logic                             trigger_latch_o,
  output logic                             out_prog_o,
  output logic                             bus_activity_o,
  output logic                             full_o,
  output logic                             error_o,
  output logic                             data_ready_o,
  output logic      [tdcb_pkg::FLAGS_W-1:0] tdc_flags_o,
  output logic      [11:0]                 win_width_o,
  output logic      [15:0]                 win_offset_o,
  output logic      [11:0]                 search_o,
  output logic      [11:0]                 reject_o,
  output logic      [1:0]                  dead_time_o,
  output logic      [2:0]                  fifo_size_o,
  output logic      [3:0]                  hit_limit_o,
  output logic      [11:0]                 glob_off_o,
  output logic      [31:0]                 chan_en_o,
  output logic      [7:0]                  chan_off_o
);
  localparam int unsigned CW = $clog2(NCH);
  localparam int unsigned KW = $clog2(CONFIG_CYCLES + 1);

  // refused at elaboration, the offset table and select width cannot serve these
  if (NCH < 2 || NCH > 256)
    $error("NCH out of range");
  if (CONFIG_CYCLES < 1)
    $error("CONFIG_CYCLES must be positive");

  tdcb_pkg::tdcb_state_t state;
  tdcb_pkg::tdcb_state_t next_state;
  logic [KW-1:0]         conf_cnt;
  logic                  clear_lvl;
  logic                  bunch_rise;
  logic                  trig_rise;
  logic                  clk_ext;
  logic                  ready;
  logic                  wr_ok;
  logic [7:0]            chan_off [NCH];
  logic [CW-1:0]         chan_sel;
  logic [2:0]            out_sel;
  logic [11:0]           led_cnt;
  logic [1:0]            trig_hold;
  logic                  data_ready_indicator_src;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  tdcb_pin_sync u_clear (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pin_i    (hw_clear_i),
    .level_o  (clear_lvl),
    .rise_o   ()
  );

  tdcb_pin_sync u_bunch (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pin_i    (bunch_reset_i),
    .level_o  (),
    .rise_o   (bunch_rise)
  );

  // the or sits ahead of the synchroniser so both pins share one path
  tdcb_pin_sync u_trig (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pin_i    (latch_trigger_i | ext_trigger_i), // RULE22
    .level_o  (),
    .rise_o   (trig_rise)
  );

  tdcb_pin_sync u_clk (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pin_i    (clk_ext_sel_i),
    .level_o  (clk_ext),
    .rise_o   ()
  );

  // switch is static; the clock mux outside follows it, logic is rising edge
  always_ff @(posedge mclk_i or negedge resetn_i) // RULE21
  begin
    if (!resetn_i)
      clk_sel_o <= 1'b0;
    else
      clk_sel_o <= clk_ext; // RULE1
  end

  assign ready = (state == tdcb_pkg::ST_READY);
  assign wr_ok = bus_we_i & ready;

  always_comb
  begin
    next_state = state;
    unique case (state)
      tdcb_pkg::ST_CLEAR:  next_state = tdcb_pkg::ST_CONFIG;
      tdcb_pkg::ST_CONFIG: if (conf_cnt == KW'(CONFIG_CYCLES - 1)) next_state = tdcb_pkg::ST_READY;
      tdcb_pkg::ST_READY:  next_state = tdcb_pkg::ST_READY;
      default:             next_state = tdcb_pkg::ST_CLEAR;
    endcase
    if (clear_lvl)
      next_state = tdcb_pkg::ST_CLEAR; // RULE3
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state <= tdcb_pkg::ST_CLEAR;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      conf_cnt <= '0;
    else if (state != tdcb_pkg::ST_CONFIG)
      conf_cnt <= '0;
    else
      conf_cnt <= conf_cnt + KW'(1);
  end

  // buffer is emptied until configuring ends
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      buffer_clear_o <= 1'b1;
    else
      buffer_clear_o <= (next_state != tdcb_pkg::ST_READY); // RULE12 RULE23
  end

  // defaults held while not ready; host must rewrite afterwards
  always_ff @(posedge mclk_i or negedge resetn_i) // RULE20
  begin
    if (!resetn_i)
    begin
      tdc_flags_o  <= tdcb_pkg::D_TDC_FLAGS;
      win_width_o  <= tdcb_pkg::D_WIN_WIDTH;
      win_offset_o <= tdcb_pkg::D_WIN_OFFSET;
      search_o     <= tdcb_pkg::D_SEARCH;
      reject_o     <= tdcb_pkg::D_REJECT;
      dead_time_o  <= tdcb_pkg::D_DEAD_TIME;
      fifo_size_o  <= tdcb_pkg::D_FIFO_SIZE;
      hit_limit_o  <= tdcb_pkg::D_HIT_LIMIT;
      glob_off_o   <= tdcb_pkg::D_GLOB_OFF;
      chan_en_o    <= '1;
      chan_sel     <= '0;
      out_sel      <= tdcb_pkg::D_OUT_SEL;
    end
    else if (!ready)
    begin
      tdc_flags_o  <= tdcb_pkg::D_TDC_FLAGS;  // RULE13 RULE14 RULE23
      win_width_o  <= tdcb_pkg::D_WIN_WIDTH;  // RULE15
      win_offset_o <= tdcb_pkg::D_WIN_OFFSET;
      search_o     <= tdcb_pkg::D_SEARCH;
      reject_o     <= tdcb_pkg::D_REJECT;
      dead_time_o  <= tdcb_pkg::D_DEAD_TIME;  // RULE16
      fifo_size_o  <= tdcb_pkg::D_FIFO_SIZE;  // RULE17
      hit_limit_o  <= tdcb_pkg::D_HIT_LIMIT;  // RULE18
      glob_off_o   <= tdcb_pkg::D_GLOB_OFF;
      chan_en_o    <= '1;
      chan_sel     <= '0;
      out_sel      <= tdcb_pkg::D_OUT_SEL;
    end
    else if (wr_ok)
    begin
      if (hit(bus_addr_i, tdcb_pkg::A_TDC_FLAGS))  tdc_flags_o  <= bus_wdata_i[tdcb_pkg::FLAGS_W-1:0];
      if (hit(bus_addr_i, tdcb_pkg::A_WIN_WIDTH))  win_width_o  <= bus_wdata_i[11:0];
      if (hit(bus_addr_i, tdcb_pkg::A_WIN_OFFSET)) win_offset_o <= bus_wdata_i[15:0];
      if (hit(bus_addr_i, tdcb_pkg::A_SEARCH))     search_o     <= bus_wdata_i[11:0];
      if (hit(bus_addr_i, tdcb_pkg::A_REJECT))     reject_o     <= bus_wdata_i[11:0];
      if (hit(bus_addr_i, tdcb_pkg::A_DEAD_TIME))  dead_time_o  <= bus_wdata_i[1:0];
      if (hit(bus_addr_i, tdcb_pkg::A_FIFO_SIZE))  fifo_size_o  <= bus_wdata_i[2:0];
      if (hit(bus_addr_i, tdcb_pkg::A_HIT_LIMIT))  hit_limit_o  <= bus_wdata_i[3:0];
      if (hit(bus_addr_i, tdcb_pkg::A_GLOB_OFF))   glob_off_o   <= bus_wdata_i[11:0];
      if (hit(bus_addr_i, tdcb_pkg::A_CHAN_EN))    chan_en_o    <= bus_wdata_i;
      if (hit(bus_addr_i, tdcb_pkg::A_CHAN_SEL))   chan_sel     <= bus_wdata_i[CW-1:0];
      if (hit(bus_addr_i, tdcb_pkg::A_OUT_SEL))    out_sel      <= bus_wdata_i[2:0]; // RULE6
    end
  end

  // per channel offsets, indexed through the select register
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < NCH; i++)
        chan_off[i] <= tdcb_pkg::D_CHAN_OFF;
    end
    else if (!ready)
    begin
      for (int i = 0; i < NCH; i++)
        chan_off[i] <= tdcb_pkg::D_CHAN_OFF; // RULE14
    end
    else if (wr_ok && hit(bus_addr_i, tdcb_pkg::A_CHAN_OFF))
      chan_off[chan_sel] <= bus_wdata_i[7:0];
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      chan_off_o <= tdcb_pkg::D_CHAN_OFF;
    else
      chan_off_o <= chan_off[chan_off_sel_i];
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      bus_rdata_o <= '0;
    else if (!bus_re_i)
      bus_rdata_o <= '0;
    else
    begin
      bus_rdata_o <= '0;
      unique case (bus_addr_i)
        tdcb_pkg::A_TDC_FLAGS:  bus_rdata_o <= 32'(tdc_flags_o);
        tdcb_pkg::A_WIN_WIDTH:  bus_rdata_o <= 32'(win_width_o);
        tdcb_pkg::A_WIN_OFFSET: bus_rdata_o <= 32'(win_offset_o);
        tdcb_pkg::A_SEARCH:     bus_rdata_o <= 32'(search_o);
        tdcb_pkg::A_REJECT:     bus_rdata_o <= 32'(reject_o);
        tdcb_pkg::A_DEAD_TIME:  bus_rdata_o <= 32'(dead_time_o);
        tdcb_pkg::A_FIFO_SIZE:  bus_rdata_o <= 32'(fifo_size_o);
        tdcb_pkg::A_HIT_LIMIT:  bus_rdata_o <= 32'(hit_limit_o);
        tdcb_pkg::A_GLOB_OFF:   bus_rdata_o <= 32'(glob_off_o);
        tdcb_pkg::A_CHAN_EN:    bus_rdata_o <= chan_en_o;
        tdcb_pkg::A_CHAN_OFF:   bus_rdata_o <= 32'(chan_off[chan_sel]);
        tdcb_pkg::A_CHAN_SEL:   bus_rdata_o <= 32'(chan_sel);
        tdcb_pkg::A_OUT_SEL:    bus_rdata_o <= 32'(out_sel);
        tdcb_pkg::A_STATUS:     bus_rdata_o <= 32'({clk_ext, data_ready_o, error_o, full_o, ~ready});
        tdcb_pkg::A_CAPS:       bus_rdata_o <= tdcb_pkg::CAPS; // RULE11
        default:                bus_rdata_o <= '0;
      endcase
    end
  end

  // stretched so a single access is visible on the panel
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      led_cnt <= '0;
    else if (bus_we_i || bus_re_i)
      led_cnt <= 12'(tdcb_pkg::BUS_LED_CYC); // RULE7
    else if (led_cnt != '0)
      led_cnt <= led_cnt - 12'h001;
  end

  assign bus_activity_o = (led_cnt != '0);

  // edges closer than the double trigger resolution are dropped
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      trig_hold       <= '0;
      trigger_latch_o <= 1'b0;
    end
    else
    begin
      trigger_latch_o <= trig_rise && (trig_hold == '0) && ready; // RULE5
      if (trig_rise && trig_hold == '0 && ready)
        trig_hold <= 2'(tdcb_pkg::TRIG_RES_CYC - 1);
      else if (trig_hold != '0)
        trig_hold <= trig_hold - 2'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      bunch_reset_o <= 1'b0;
    else
      bunch_reset_o <= bunch_rise; // RULE4
  end

  assign data_ready_indicator_src = tdc_flags_o[tdcb_pkg::F_TRIG_MATCH] ? buffer_event_i : buffer_data_i; // RULE10

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      full_o       <= 1'b1;
      error_o      <= 1'b1;
      data_ready_o <= 1'b1;
    end
    else
    begin
      full_o       <= !ready || buffer_full_i; // RULE8 RULE19
      error_o      <= !ready || tdc_error_i;   // RULE9
      data_ready_o <= !ready || data_ready_indicator_src;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      out_prog_o <= 1'b0;
    else
    begin
      unique case (out_sel) // RULE6
        tdcb_pkg::OP_LOW:   out_prog_o <= 1'b0;
        tdcb_pkg::OP_DATA_READY_INDICATOR:  out_prog_o <= data_ready_o;
        tdcb_pkg::OP_FULL:  out_prog_o <= full_o;
        tdcb_pkg::OP_ERROR: out_prog_o <= error_o;
        tdcb_pkg::OP_TRIG:  out_prog_o <= trigger_latch_o;
        tdcb_pkg::OP_BUNCH: out_prog_o <= bunch_reset_o;
        tdcb_pkg::OP_CONF:  out_prog_o <= !ready;
        tdcb_pkg::OP_HIGH:  out_prog_o <= 1'b1;
      endcase
    end
  end

  property p_clear;
    @(posedge mclk_i) disable iff (!resetn_i) clear_lvl |=> state == tdcb_pkg::ST_CLEAR;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not hold state"); // RULE3

  property p_bunch;
    @(posedge mclk_i) disable iff (!resetn_i) $rose(u_bunch.level_o) |=> bunch_reset_o ##1 !bunch_reset_o;
  endproperty
  a_bunch: assert property (p_bunch) else $error("bunch reset pulse wrong"); // RULE4

  property p_trig;
    @(posedge mclk_i) disable iff (!resetn_i) trigger_latch_o |-> $past(trig_rise) && $past(ready) ##1 !trigger_latch_o;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger latch without edge"); // RULE5

  property p_led;
    @(posedge mclk_i) disable iff (!resetn_i) (bus_we_i || bus_re_i) |=> bus_activity_o[*8];
  endproperty
  a_led: assert property (p_led) else $error("activity led not lit"); // RULE7

  property p_full;
    @(posedge mclk_i) disable iff (!resetn_i) ready && buffer_full_i |=> full_o;
  endproperty
  a_full: assert property (p_full) else $error("full indicator missing"); // RULE8

  property p_err;
    @(posedge mclk_i) disable iff (!resetn_i) ready ##1 ready && !tdc_error_i |=> error_o == 1'b0;
  endproperty
  a_err: assert property (p_err) else $error("error indicator stuck"); // RULE9

  property p_data_ready_indicator;
    @(posedge mclk_i) disable iff (!resetn_i) ready && !tdc_flags_o[tdcb_pkg::F_TRIG_MATCH] && buffer_data_i |=> data_ready_o;
  endproperty
  a_data_ready_indicator: assert property (p_data_ready_indicator) else $error("data ready missing"); // RULE10

  property p_conf;
    @(posedge mclk_i) disable iff (!resetn_i) !ready |-> buffer_clear_o ##1 full_o && error_o && data_ready_o;
  endproperty
  a_conf: assert property (p_conf) else $error("configuring indication wrong"); // RULE19

  property p_dflt;
    @(posedge mclk_i) disable iff (!resetn_i) state == tdcb_pkg::ST_CONFIG |=>
      win_width_o == tdcb_pkg::D_WIN_WIDTH && win_offset_o == tdcb_pkg::D_WIN_OFFSET &&
      search_o == tdcb_pkg::D_SEARCH && reject_o == tdcb_pkg::D_REJECT;
  endproperty
  a_dflt: assert property (p_dflt) else $error("window defaults wrong"); // RULE15

  property p_lims;
    @(posedge mclk_i) disable iff (!resetn_i) state == tdcb_pkg::ST_CONFIG |=>
      fifo_size_o == tdcb_pkg::D_FIFO_SIZE && hit_limit_o == tdcb_pkg::D_HIT_LIMIT &&
      dead_time_o == tdcb_pkg::D_DEAD_TIME && tdc_flags_o == tdcb_pkg::D_TDC_FLAGS;
  endproperty
  a_lims: assert property (p_lims) else $error("tdc defaults wrong"); // RULE14
endmodule
`default_nettype wire

// ### src/tdcb_pin_sync.sv
// Purpose: two-stage synchroniser with rising edge detect
// Assumes: pin is asynchronous to mclk_i
// Notes:   edge is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module tdcb_pin_sync (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta;
  logic prev;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta    <= 1'b0;
      level_o <= 1'b0;
      prev    <= 1'b0;
    end
    else
    begin
      meta    <= pin_i;
      level_o <= meta;
      prev    <= level_o;
    end
  end

  assign rise_o = level_o & ~prev;
endmodule
`default_nettype wire

// ### src/tdcb_pkg.sv
// Purpose: constants for the tdc board reset and defaults block
// Assumes: 40 MHz mclk_i, 32-bit register port with byte offsets
// Notes:   default codes are loaded after reset and hardware clear
package tdcb_pkg;
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  // minimum pin pulse width and double trigger resolution
  localparam int unsigned PULSE_MIN_NS   = 25;
  localparam int unsigned PULSE_MIN_CYC  = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_RES_NS    = 75;
  localparam int unsigned TRIG_RES_CYC   = (TRIG_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUS_LED_NS     = 100000;
  localparam int unsigned BUS_LED_CYC    = BUS_LED_NS / CLK_PERIOD_NS;
  localparam int unsigned CONFIG_MS      = 1000;
  localparam int unsigned CONFIG_CYC     = CONFIG_MS * 1000 * CLK_MHZ;

  localparam logic [7:0] A_TDC_FLAGS   = 8'h00;
  localparam logic [7:0] A_WIN_WIDTH   = 8'h04;
  localparam logic [7:0] A_WIN_OFFSET  = 8'h08;
  localparam logic [7:0] A_SEARCH      = 8'h0c;
  localparam logic [7:0] A_REJECT      = 8'h10;
  localparam logic [7:0] A_DEAD_TIME   = 8'h14;
  localparam logic [7:0] A_FIFO_SIZE   = 8'h18;
  localparam logic [7:0] A_HIT_LIMIT   = 8'h1c;
  localparam logic [7:0] A_GLOB_OFF    = 8'h20;
  localparam logic [7:0] A_CHAN_EN     = 8'h24;
  localparam logic [7:0] A_CHAN_OFF    = 8'h28;
  localparam logic [7:0] A_CHAN_SEL    = 8'h2c;
  localparam logic [7:0] A_OUT_SEL     = 8'h30;
  localparam logic [7:0] A_STATUS      = 8'h34;
  localparam logic [7:0] A_CAPS        = 8'h38;

  // tdc flag field positions
  localparam int unsigned F_TRIG_MATCH = 0;
  localparam int unsigned F_KEEP_TOKEN = 1;
  localparam int unsigned F_SUB_TRIG   = 2;
  localparam int unsigned F_HDR_TRL    = 3;
  localparam int unsigned F_ERR_MARK   = 4;
  localparam int unsigned F_ERR_BYPASS = 5;
  localparam int unsigned F_EDGE_LO    = 6;
  localparam int unsigned F_RES_LO     = 8;
  localparam int unsigned F_PAIR_LO    = 10;
  localparam int unsigned F_ERRT_LO    = 12;
  localparam int unsigned ERRT_W       = 11;
  localparam int unsigned FLAGS_W      = F_ERRT_LO + ERRT_W;

  // leading edge 2'h1, resolution code 2'h0 = 100 ps, all error types on
  localparam logic [FLAGS_W-1:0] D_TDC_FLAGS = 23'h7ff05a;
  localparam logic [11:0] D_WIN_WIDTH  = 12'h014;
  localparam logic [15:0] D_WIN_OFFSET = 16'hffd8;
  localparam logic [11:0] D_SEARCH     = 12'h008;
  localparam logic [11:0] D_REJECT     = 12'h004;
  localparam logic [1:0]  D_DEAD_TIME  = 2'h0;   // 5 ns
  localparam logic [2:0]  D_FIFO_SIZE  = 3'h7;   // 256 words
  localparam logic [3:0]  D_HIT_LIMIT  = 4'h9;   // no limit
  localparam logic [11:0] D_GLOB_OFF   = 12'h000;
  localparam logic [7:0]  D_CHAN_OFF   = 8'h00;
  localparam logic [2:0]  D_OUT_SEL    = 3'h0;

  // out_prog functions
  localparam logic [2:0] OP_LOW   = 3'h0;
  localparam logic [2:0] OP_DATA_READY_INDICATOR  = 3'h1;
  localparam logic [2:0] OP_FULL  = 3'h2;
  localparam logic [2:0] OP_ERROR = 3'h3;
  localparam logic [2:0] OP_TRIG  = 3'h4;
  localparam logic [2:0] OP_BUNCH = 3'h5;
  localparam logic [2:0] OP_CONF  = 3'h6;
  localparam logic [2:0] OP_HIGH  = 3'h7;

  // status bits
  localparam int unsigned S_CONF = 0;
  localparam int unsigned S_FULL = 1;
  localparam int unsigned S_ERR  = 2;
  localparam int unsigned S_DATA_READY_INDICATOR = 3;
  localparam int unsigned S_CLK  = 4;

  // a24, a32, multicast, d16, d32, blt, cblt, 2e modes
  localparam logic [31:0] CAPS = 32'h000000ff;

  typedef enum logic [1:0] {
    ST_CLEAR  = 2'h0,
    ST_CONFIG = 2'h1,
    ST_READY  = 2'h3
  } tdcb_state_t;
endpackage

// ### verif/tdcb_board_tb_top.sv
// Purpose: self-checking bench for the board block
// Assumes: configuring shortened to 20 cycles
// Notes:   pins come from the panel model
`timescale 1ns/100ps
`default_nettype none
module tdcb_board_tb_top;
  logic        mclk_i, resetn_i, ext_sel, full_in, data_in, evt_in, err_in, we, re;
  logic        clr, bun, latch_trigger_input, etrg, clk_sel, buf_clr, bun_p, trg_p, outp, act, full_o, err_o, data_ready_indicator_o;
  logic [7:0]  addr, choff;
  logic [31:0] wdata, rdata, chen;
  logic [22:0] flags;
  logic [11:0] width, search, reject, glob;
  logic [15:0] offs;
  logic [1:0]  dead;
  logic [2:0]  fifo;
  logic [3:0]  hits;
  logic [6:0]  sel;
  int          num_errors = 0, samples_checked = 0, trg_cnt = 0, bun_cnt = 0;

  tdcb_panel_model panel_u (.mclk_i(mclk_i), .clear_o(clr), .bunch_o(bun), .trig_o(latch_trigger_input), .ext_trig_o(etrg));
  tdcb_board #(.CONFIG_CYCLES(20)) dut_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .clk_ext_sel_i(ext_sel), .hw_clear_i(clr), .bunch_reset_i(bun),
    .latch_trigger_i(latch_trigger_input), .ext_trigger_i(etrg), .buffer_full_i(full_in), .buffer_data_i(data_in),
    .buffer_event_i(evt_in), .tdc_error_i(err_in), .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_we_i(we),
    .bus_re_i(re), .chan_off_sel_i(sel), .bus_rdata_o(rdata), .clk_sel_o(clk_sel), .buffer_clear_o(buf_clr),
    .bunch_reset_o(bun_p), .trigger_latch_o(trg_p), .out_prog_o(outp), .bus_activity_o(act), .full_o(full_o),
    .error_o(err_o), .data_ready_o(data_ready_indicator_o), .tdc_flags_o(flags), .win_width_o(width), .win_offset_o(offs),
    .search_o(search), .reject_o(reject), .dead_time_o(dead), .fifo_size_o(fifo), .hit_limit_o(hits),
    .glob_off_o(glob), .chan_en_o(chen), .chan_off_o(choff));

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    trg_cnt += int'(trg_p);
    bun_cnt += int'(bun_p);
  end

  task automatic give_verdict;
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // model of the programmable output; v is {err, full, data}
  function automatic logic exp_out(int s, logic [2:0] v);
    case (s)
      1: return v[0];
      2: return v[1];
      3: return v[2];
      7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {we, addr, wdata} <= {1'b1, a, d};
    @(posedge mclk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    {re, addr} <= {1'b1, a};
    @(posedge mclk_i);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // full_o drops only when configuring ends, buffer_full_i held low
  task automatic wait_ready;
    int n = 0;
    while (full_o !== 1'b0 && n < 200)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (full_o !== 1'b0)
    begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic check_defaults;
    chk(flags, tdcb_pkg::D_TDC_FLAGS);
    chk({width, offs, search, reject}, {12'h014, 16'hffd8, 12'h008, 12'h004});
    chk({dead, fifo, hits}, {tdcb_pkg::D_DEAD_TIME, tdcb_pkg::D_FIFO_SIZE, tdcb_pkg::D_HIT_LIMIT});
    chk({glob, chen, choff}, {12'h000, 32'hffffffff, 8'h00});
  endtask

  initial
  begin
    logic [2:0]  v;
    logic [31:0] r;
    void'($urandom(43157));
    {resetn_i, ext_sel, full_in, data_in, evt_in, err_in, we, re} = 8'h00;
    {addr, wdata, sel} = '0;
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    #1 chk({full_o, err_o, data_ready_indicator_o, buf_clr}, 4'hf);
    wait_ready();
    chk({full_o, err_o, data_ready_indicator_o, buf_clr, act}, 5'h00);
    check_defaults();
    rd(tdcb_pkg::A_STATUS, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      r = $urandom;
      wr(tdcb_pkg::A_CHAN_SEL, r);
      sel <= r[6:0];
      wr(tdcb_pkg::A_CHAN_OFF, r >> 8);
      wr(tdcb_pkg::A_WIN_WIDTH, r);
      rd(tdcb_pkg::A_WIN_WIDTH, {20'h0, r[11:0]});
      rd(tdcb_pkg::A_CHAN_OFF, {24'h0, r[15:8]});
      chk({width, choff}, {r[11:0], r[15:8]});
    end
    rd(8'h3c, 32'h0);
    rd(tdcb_pkg::A_CAPS, tdcb_pkg::CAPS);
    for (int s = 0; s < 8; s++)
    begin
      wr(tdcb_pkg::A_OUT_SEL, 32'(s));
      v = 3'($urandom);
      {err_in, full_in, data_in} <= v;
      repeat (3) @(posedge mclk_i);
      #1 chk({full_o, err_o, data_ready_indicator_o}, {v[1], v[2], v[0]});
      chk(outp, exp_out(s, v));
    end
    chk(act, 1'b1);
    @(posedge mclk_i);
    {err_in, full_in, data_in} <= 3'h0;
    // event mode: data_ready_indicator must follow the event input, data input held low
    wr(tdcb_pkg::A_TDC_FLAGS, 32'(tdcb_pkg::D_TDC_FLAGS) | 32'h1);
    evt_in <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 chk(data_ready_indicator_o, 1'b1);
    wr(tdcb_pkg::A_TDC_FLAGS, 32'(tdcb_pkg::D_TDC_FLAGS));
    evt_in <= 1'b0;
    for (int k = 1; k < 4; k++)
    begin
      panel_u.pulse(k);
      repeat (2) @(posedge mclk_i);
    end
    repeat (5) @(posedge mclk_i);
    chk({trg_cnt, bun_cnt}, {32'd2, 32'd1});
    ext_sel <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(tdcb_pkg::A_STATUS, 32'h10);
    @(posedge mclk_i);
    #1 chk(rdata, 32'h0);
    chk(clk_sel, 1'b1);
    panel_u.pulse(0);
    repeat (5) @(posedge mclk_i);
    #1 chk({buf_clr, full_o}, 2'h3);
    wr(tdcb_pkg::A_WIN_WIDTH, 32'h123);
    wait_ready();
    check_defaults();
    wr(tdcb_pkg::A_WIN_WIDTH, 32'h123);
    rd(tdcb_pkg::A_WIN_WIDTH, 32'h123);
    repeat (tdcb_pkg::BUS_LED_CYC) @(posedge mclk_i);
    #1 chk(act, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire

// ### verif/tdcb_panel_model.sv
// Purpose: pin sources on the control connector
// Assumes: bench clock at most 40 MHz
// Notes:   pulses span two cycles, 50 ns
`timescale 1ns/100ps
`default_nettype none
module tdcb_panel_model (
  input  wire logic mclk_i,
  output logic      clear_o,
  output logic      bunch_o,
  output logic      trig_o,
  output logic      ext_trig_o
);
  initial {clear_o, bunch_o, trig_o, ext_trig_o} = 4'h0;
  // 0 clear, 1 bunch, 2 trigger, 3 ext trigger; released pins idle low
  task automatic pulse(input int kind);
    @(posedge mclk_i);
    case (kind)
      0: clear_o <= 1'b1;
      1: bunch_o <= 1'b1;
      2: trig_o <= 1'b1;
      default: ext_trig_o <= 1'b1;
    endcase
    repeat (2) @(posedge mclk_i);
    {clear_o, bunch_o, trig_o, ext_trig_o} <= 4'h0;
  endtask
endmodule
`default_nettype wire
